// File: src/alx_core.sv
// Design decisions made here: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/100ps
module alx_core
  import alx_pkg::*;
#(
  parameter int FILE_DEPTH     = 128,
  parameter int INDIRECT_ADDR  = 0
)
(
  input  wire logic         sys_clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [7:0]   s_axi_awaddr_i,
  input  wire logic         s_axi_awvalid_i,
  output logic              s_axi_awready_o,
  input  wire logic [31:0]  s_axi_wdata_i,
  input  wire logic [3:0]   s_axi_wstrb_i,
  input  wire logic         s_axi_wvalid_i,
  output logic              s_axi_wready_o,
  output logic [1:0]        s_axi_bresp_o,
  output logic              s_axi_bvalid_o,
  input  wire logic         s_axi_bready_i,
  input  wire logic [7:0]   s_axi_araddr_i,
  input  wire logic         s_axi_arvalid_i,
  output logic              s_axi_arready_o,
  output logic [31:0]       s_axi_rdata_o,
  output logic [1:0]        s_axi_rresp_o,
  output logic              s_axi_rvalid_o,
  input  wire logic         s_axi_rready_i,
  output logic              busy_o
);

  // architectural state
  logic [DATA_W-1:0]  acc;
  logic [PTR_W-1:0]   ptr0;
  logic [PTR_W-1:0]   ptr1;
  logic               flag_c;
  logic               flag_hc;
  logic               flag_z;
  logic [DATA_W-1:0]  last_res;
  logic [DATA_W-1:0]  file_mem [FILE_DEPTH];

  // latched instruction fields
  logic [31:0]        ctrl;
  alx_state_t         state;
  alx_state_t         next_state;

  // bus slave state
  logic               aw_held;
  logic               w_held;
  logic [7:0]         aw_addr;
  logic [31:0]        w_data;
  logic [3:0]         w_strb;

  // instruction field decode from the control word
  wire alx_op_t            op_cur = alx_op_t'(ctrl[CTRL_OP_LSB +: 4]);
  wire                     dest   = ctrl[CTRL_DEST_BIT];
  wire                     psel   = ctrl[CTRL_SEL_BIT];
  wire [BIDX_W-1:0]        bidx   = ctrl[CTRL_BIDX_LSB +: BIDX_W];
  wire [FADDR_W-1:0]       faddr  = ctrl[CTRL_FADDR_LSB +: FADDR_W];
  wire [DATA_W-1:0]        imm    = ctrl[CTRL_IMM_LSB +: DATA_W];
  wire [LIT6_W-1:0]        lit6   = ctrl[CTRL_IMM_LSB +: LIT6_W];

  // classify the operation
  function automatic logic is_file_op(input alx_op_t op);
    is_file_op = (op == ALX_OP_ANDF) || (op == ALX_OP_ADDF) || (op == ALX_OP_ARITH_SHIFT_RIGHT)
              || (op == ALX_OP_ADDC) || (op == ALX_OP_BCLR);
  endfunction

  function automatic logic is_add_op(input alx_op_t op);
    is_add_op = (op == ALX_OP_ADDI) || (op == ALX_OP_ADDF) || (op == ALX_OP_ADDC);
  endfunction

  // register map hit test; status and result accept writes but keep their value
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == REG_CTRL) || (a == REG_ACC) || (a == REG_STATUS)
             || (a == REG_PTR0) || (a == REG_PTR1) || (a == REG_RESULT);
  endfunction

  // the indirect port reads through pointer 0; only low bits index the local file
  // pointer 1 never backs the indirect port here, so only pointer 0 can stall
  wire               indirect   = (faddr == FADDR_W'(INDIRECT_ADDR));
  wire [FADDR_W-1:0] eff_addr   = indirect ? ptr0[FADDR_W-1:0] : faddr;
  wire [DATA_W-1:0]  file_rd    = file_mem[eff_addr];
  wire               need_stall = is_file_op(op_cur) && indirect && ptr0[PTR_W-1];

  // alu and pointer adder
  logic [DATA_W-1:0] alu_res;
  logic              alu_c;
  logic              alu_hc;
  logic              alu_z;
  logic [PTR_W-1:0]  ptr_sum;

  // one shared alu serves every 8-bit operation
  alx_alu u_alu (
    .op_i     (op_cur),
    .acc_i    (acc),
    .file_i   (file_rd),
    .imm_i    (imm),
    .bidx_i   (bidx),
    .carry_i  (flag_c),
    .res_o    (alu_res),
    .carry_o  (alu_c),
    .hcarry_o (alu_hc),
    .zero_o   (alu_z)
  );

  // the pointer adder is separate so a pointer add never disturbs the flags
  alx_ptr_add u_padd (
    .ptr_i (psel ? ptr1 : ptr0),
    .lit_i (lit6),
    .ptr_o (ptr_sum)
  );

  // write channel handshake: address and data taken in either order
  // a pending response blocks both channels until it is accepted
  wire aw_take  = s_axi_awvalid_i && !aw_held && !s_axi_bvalid_o;
  wire w_take   = s_axi_wvalid_i && !w_held && !s_axi_bvalid_o;
  wire wr_fire  = aw_held && w_held && !s_axi_bvalid_o;
  wire ar_take  = s_axi_arvalid_i && !s_axi_rvalid_o;
  wire wr_ctrl  = wr_fire && (aw_addr == REG_CTRL);
  wire wr_acc   = wr_fire && (aw_addr == REG_ACC);
  wire wr_p0    = wr_fire && (aw_addr == REG_PTR0);
  wire wr_p1    = wr_fire && (aw_addr == REG_PTR1);
  wire wr_map   = is_mapped(aw_addr);
  // a new go is refused while the sequencer is busy
  wire start    = wr_ctrl && w_data[CTRL_GO_BIT] && w_strb[3] && (state == ALX_ST_IDLE);

  assign s_axi_awready_o = !aw_held && !s_axi_bvalid_o;
  assign s_axi_wready_o  = !w_held && !s_axi_bvalid_o;
  assign s_axi_arready_o = !s_axi_rvalid_o;
  assign busy_o          = (state == ALX_ST_STALL);

  // sequencer: go is latched one cycle, execute happens the cycle after,
  // delayed one more when the indirect pointer points high
  logic go_q;
  wire  exec = (state == ALX_ST_IDLE) && go_q && !need_stall
            || (state == ALX_ST_STALL);

  // which flags and targets a committed operation touches
  wire upd_z   = (op_cur != ALX_OP_BCLR);
  wire upd_c   = is_add_op(op_cur) || (op_cur == ALX_OP_ARITH_SHIFT_RIGHT);
  wire upd_hc  = is_add_op(op_cur);
  wire to_file = exec && is_file_op(op_cur)
              && (dest == DEST_FILE || op_cur == ALX_OP_BCLR);

  // next state: one extra cycle when a high pointer backs the indirect port
  always_comb
  begin
    next_state = state;
    case (state)
      ALX_ST_IDLE:  if (go_q && need_stall) next_state = ALX_ST_STALL;
      ALX_ST_STALL: next_state = ALX_ST_IDLE;
      default:      next_state = ALX_ST_IDLE;
    endcase
  end

  // sequencer state and the go pulse
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      state <= ALX_ST_IDLE;
      go_q  <= 1'b0;
    end
    else
    begin
      state <= next_state;
      go_q  <= start;
    end
  end

  // bus capture registers
  // each half is held alone so address and data may arrive in either order
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end
    else
    begin
      if (aw_take)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr_i;
      end
      else if (wr_fire)
        aw_held <= 1'b0;
      if (w_take)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata_i;
        w_strb <= s_axi_wstrb_i;
      end
      else if (wr_fire)
        w_held <= 1'b0;
    end
  end

  // status word built from the package bit positions
  logic [31:0] status_word;
  always_comb
  begin
    status_word              = 32'h0000_0000;
    status_word[ST_C_BIT]    = flag_c;
    status_word[ST_HC_BIT]   = flag_hc;
    status_word[ST_Z_BIT]    = flag_z;
    status_word[ST_BUSY_BIT] = busy_o;
  end

  // write response and read data
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= RESP_OKAY;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rresp_o  <= RESP_OKAY;
      s_axi_rdata_o  <= 32'h0000_0000;
    end
    else
    begin
      if (wr_fire)
      begin
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o  <= wr_map ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready_i)
        s_axi_bvalid_o <= 1'b0;
      // unmapped reads answer zero with SLVERR
      if (ar_take)
      begin
        s_axi_rvalid_o <= 1'b1;
        s_axi_rresp_o  <= RESP_OKAY;
        case (s_axi_araddr_i)
          REG_CTRL:   s_axi_rdata_o <= {1'b0, ctrl[30:0]};
          REG_ACC:    s_axi_rdata_o <= {24'h000000, acc};
          REG_STATUS: s_axi_rdata_o <= status_word;
          REG_PTR0:   s_axi_rdata_o <= {16'h0000, ptr0};
          REG_PTR1:   s_axi_rdata_o <= {16'h0000, ptr1};
          REG_RESULT: s_axi_rdata_o <= {24'h000000, last_res};
          default:
          begin
            s_axi_rdata_o <= 32'h0000_0000;
            s_axi_rresp_o <= RESP_SLVERR;
          end
        endcase
      end
      else if (s_axi_rready_i)
        s_axi_rvalid_o <= 1'b0;
    end
  end

  // control word: byte enables respected, the go bit reads back as zero
  // a control write while a go is pending is dropped but still answered OKAY
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
      ctrl <= 32'h0000_0000;
    else if (wr_ctrl && (state == ALX_ST_IDLE) && !go_q)
    begin
      for (int i = 0; i < 4; i++)
        if (w_strb[i])
          ctrl[i*8 +: 8] <= w_data[i*8 +: 8];
    end
  end

  // accumulator, pointers and flags
  // a bus write to acc or a pointer in the commit cycle is lost: the commit wins,
  // so software should not write them right behind a go
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      acc      <= ACC_RST;
      ptr0     <= PTR_RST;
      ptr1     <= PTR_RST;
      flag_c   <= 1'b0;
      flag_hc  <= 1'b0;
      flag_z   <= 1'b0;
      last_res <= 8'h00;
    end
    else if (exec)
    begin
      if (op_cur == ALX_OP_PADD)
      begin
        if (psel)
          ptr1 <= ptr_sum;
        else
          ptr0 <= ptr_sum;
      end
      else if (op_cur != ALX_OP_NONE)
      begin
        last_res <= alu_res;
        // immediates always target the accumulator; file ops other than bit_clear_op honour dest
        if (!is_file_op(op_cur) || dest == DEST_ACC)
        begin
          if (op_cur != ALX_OP_BCLR)
            acc <= alu_res;
        end
        if (upd_z)
          flag_z <= alu_z;
        if (upd_c)
          flag_c <= alu_c;
        if (upd_hc)
          flag_hc <= alu_hc;
      end
    end
    else
    begin
      if (wr_acc && w_strb[0])
        acc <= w_data[7:0];
      if (wr_p0)
        ptr0 <= w_data[15:0];
      if (wr_p1)
        ptr1 <= w_data[15:0];
    end
  end

  // file register write-back: no reset, contents are data memory
  // bit_clear_op always writes here, whatever the destination bit says
  always_ff @(posedge sys_clk_i)
  begin
    if (to_file)
      file_mem[eff_addr] <= alu_res;
  end

endmodule

// File: src/alx_pkg.sv
// shared constants for the literal and file-register execution datapath
package alx_pkg;

  localparam int DATA_W  = 8;
  localparam int PTR_W   = 16;
  localparam int LIT6_W  = 6;
  localparam int FADDR_W = 7;
  localparam int BIDX_W  = 3;

  // operation select codes
  typedef enum logic [3:0] {
    ALX_OP_NONE  = 4'h0,
    ALX_OP_PADD  = 4'h1,
    ALX_OP_ANDI  = 4'h2,
    ALX_OP_ADDI  = 4'h3,
    ALX_OP_ANDF  = 4'h4,
    ALX_OP_ADDF  = 4'h5,
    ALX_OP_ARITH_SHIFT_RIGHT  = 4'h6,
    ALX_OP_ADDC  = 4'h7,
    ALX_OP_BCLR  = 4'h8
  } alx_op_t;

  // execution sequencer states
  typedef enum logic [1:0] {
    ALX_ST_IDLE  = 2'b00,
    ALX_ST_STALL = 2'b01
  } alx_state_t;

  // destination bit meaning
  localparam logic DEST_ACC  = 1'b0;
  localparam logic DEST_FILE = 1'b1;

  // reset values and the pointer maximum
  localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
  localparam logic [PTR_W-1:0]  PTR_RST = 16'h0000;
  localparam logic [PTR_W-1:0]  PTR_MAX = 16'hFFFF;

  // AXI4-Lite register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_ACC    = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_PTR0   = 8'h0C;
  localparam logic [7:0] REG_PTR1   = 8'h10;
  localparam logic [7:0] REG_RESULT = 8'h14;

  // control register fields
  localparam int CTRL_OP_LSB    = 0;
  localparam int CTRL_DEST_BIT  = 4;
  localparam int CTRL_SEL_BIT   = 5;
  localparam int CTRL_BIDX_LSB  = 8;
  localparam int CTRL_FADDR_LSB = 12;
  localparam int CTRL_IMM_LSB   = 20;
  localparam int CTRL_GO_BIT    = 31;

  // status register fields
  localparam int ST_C_BIT    = 0;
  localparam int ST_HC_BIT   = 1;
  localparam int ST_Z_BIT    = 2;
  localparam int ST_BUSY_BIT = 3;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// File: src/alx_alu.sv
// combinational 8-bit arithmetic and logic unit with flag generation
`timescale 1ns/100ps
module alx_alu
  import alx_pkg::*;
(
  input  wire alx_op_t              op_i,
  input  wire logic [DATA_W-1:0]    acc_i,
  input  wire logic [DATA_W-1:0]    file_i,
  input  wire logic [DATA_W-1:0]    imm_i,
  input  wire logic [BIDX_W-1:0]    bidx_i,
  input  wire logic                 carry_i,
  output logic      [DATA_W-1:0]    res_o,
  output logic                      carry_o,
  output logic                      hcarry_o,
  output logic                      zero_o
);

  wire               use_imm = (op_i == ALX_OP_ADDI) || (op_i == ALX_OP_ANDI);
  wire [DATA_W-1:0]  opb     = use_imm ? imm_i : file_i;
  wire               cin     = (op_i == ALX_OP_ADDC) ? carry_i : 1'b0;
  // carry out of bit 3 taken from a separate low-nibble sum
  wire [4:0]         lo_sum  = {1'b0, acc_i[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
  wire [DATA_W:0]    full    = {1'b0, acc_i} + {1'b0, opb} + {8'h00, cin};
  wire [DATA_W-1:0]  clr_msk = ~(8'h01 << bidx_i);

  // result select and flag outcome per operation
  always_comb
  begin
    res_o    = 8'h00;
    carry_o  = carry_i;
    hcarry_o = 1'b0;
    case (op_i)
      ALX_OP_ANDI, ALX_OP_ANDF:
        res_o = acc_i & opb;
      ALX_OP_ADDI, ALX_OP_ADDF, ALX_OP_ADDC:
      begin
        res_o    = full[DATA_W-1:0];
        carry_o  = full[DATA_W];
        hcarry_o = lo_sum[4];
      end
      ALX_OP_ARITH_SHIFT_RIGHT:
      begin
        res_o   = {file_i[7], file_i[7:1]};
        carry_o = file_i[0];
      end
      ALX_OP_BCLR:
        res_o = file_i & clr_msk;
      default:
        res_o = 8'h00;
    endcase
    zero_o = (res_o == 8'h00);
  end

endmodule

// File: src/alx_ptr_add.sv
// indirect pointer adder with a sign-extended 6-bit literal
`timescale 1ns/100ps
module alx_ptr_add
  import alx_pkg::*;
(
  input  wire logic [PTR_W-1:0]   ptr_i,
  input  wire logic [LIT6_W-1:0]  lit_i,
  output logic      [PTR_W-1:0]   ptr_o
);

  // sign extension covers -32 to 31; the sum simply drops bit 16 so the
  // pointer wraps modulo 2^16 with no saturation
  wire [PTR_W-1:0] lit_ext = {{(PTR_W-LIT6_W){lit_i[LIT6_W-1]}}, lit_i};

  assign ptr_o = ptr_i + lit_ext;

endmodule

// File: tb/alx_core_chk.sv
// concurrent checks on the register bus and stall output of the datapath
`timescale 1ns/100ps
module alx_core_chk
(
  input wire logic        sys_clk_i,
  input wire logic        rst_n_i,
  input wire logic        s_axi_awvalid_i,
  input wire logic        s_axi_awready_o,
  input wire logic        s_axi_wvalid_i,
  input wire logic        s_axi_wready_o,
  input wire logic [1:0]  s_axi_bresp_o,
  input wire logic        s_axi_bvalid_o,
  input wire logic        s_axi_bready_i,
  input wire logic        s_axi_arvalid_i,
  input wire logic        s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic        s_axi_rvalid_o,
  input wire logic        s_axi_rready_i,
  input wire logic        busy_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  // response two edges after both write halves are taken together
  a_b_after_aw: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i &&
    s_axi_wready_o |-> ##2 s_axi_bvalid_o) else $error("write response late");
  a_b_holds: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o &&
    $stable(s_axi_bresp_o)) else $error("write response dropped");
  a_r_after_ar: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read data late");
  a_r_holds: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o &&
    $stable(s_axi_rdata_o)) else $error("read data dropped");
  a_aw_block: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
    else $error("write taken during response");
  a_ar_block: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("read taken during response");
  a_stall_one: assert property (busy_o |=> !busy_o) else $error("stall too long");
  a_reset_clear: assert property ($rose(rst_n_i) |-> !s_axi_bvalid_o && !s_axi_rvalid_o &&
    !busy_o) else $error("outputs not idle after reset");

  c_stall: cover property ($rose(busy_o));
  c_slverr: cover property (s_axi_bvalid_o && s_axi_bresp_o == 2'h2);
  c_read: cover property (s_axi_rvalid_o && s_axi_rready_i);
endmodule

// File: tb/test_cpu_alu_literal_file_ops.sv
// self-checking bench for the literal and file-register datapath
`timescale 1ns/100ps
module test_cpu_alu_literal_file_ops
  import alx_pkg::*;
;
  typedef struct {alx_op_t op; logic d; logic [6:0] fa;
                  logic [7:0] acc, fil, imm, res; logic [2:0] flg;} alx_row_t;
  logic        clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, busy;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, got;
  logic [1:0]  bresp, rresp, r;
  int          errors, compares;
  int          busy_cnt = 0;
  alx_row_t    rows [12];
  alx_row_t    q;

  alx_core dut_u (.sys_clk_i(clk), .rst_n_i(rst_n), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .busy_o(busy));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // stall cycles seen on the busy output
  always @(posedge clk)
    if (busy === 1'b1) busy_cnt <= busy_cnt + 1;

  task automatic close_out();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e)
    begin
      errors++;
      $display("mismatch at %0t: got %h want %h", $time, g, e);
    end
  endtask

  // one bus transfer; handshakes judged at the falling edge so the rising edge sees them
  task automatic bus(input bit w, input logic [7:0] a, input logic [31:0] d);
    bit ta, tw, tr, tb, done;
    @(posedge clk);
    if (w)
    begin
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
    end
    else
    begin
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
    end
    for (int i = 0; i < 40 && !done; i++)
    begin
      @(negedge clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tr = arvalid && arready;
      tb = w ? bvalid : rvalid;
      r = w ? bresp : rresp;
      got = rdata;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tr) arvalid <= 1'b0;
      if (tb)
      begin
        bready <= 1'b0;
        rready <= 1'b0;
        done = 1;
      end
    end
    if (!done)
    begin
      errors++;
      close_out();
    end
  endtask

  // go write, then room for a stalled commit before anything else touches the core
  task automatic exec(input alx_op_t op, input logic d, input logic [6:0] fa,
                      input logic [7:0] imm, input logic [2:0] bi, input logic sel);
    bus(1, REG_CTRL, {1'h1, 3'h0, imm, 1'h0, fa, 1'h0, bi, 2'h0, sel, d, op});
    repeat (2) @(posedge clk);
  endtask

  // file memory has no reset: clear every bit, then add the value in
  task automatic load_file(input logic [6:0] fa, input logic [7:0] v);
    for (int b = 0; b < 8; b++)
      exec(ALX_OP_BCLR, 1'h1, fa, 8'h00, 3'(b), 1'h0);
    bus(1, REG_ACC, {24'h0, v});
    exec(ALX_OP_ADDF, 1'h1, fa, 8'h00, 3'h0, 1'h0);
  endtask

  task automatic get_file(input logic [6:0] fa);
    bus(1, REG_ACC, 32'h0);
    exec(ALX_OP_ADDF, 1'h0, fa, 8'h00, 3'h0, 1'h0);
    bus(0, REG_ACC, 32'h0);
  endtask

  initial
  begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata} = 48'h0;
    rows = '{'{ALX_OP_ADDI, 1'h0, 7'h05, 8'h0F, 8'h01, 8'h01, 8'h10, 3'h2},
             '{ALX_OP_ADDI, 1'h0, 7'h05, 8'hFF, 8'h01, 8'h01, 8'h00, 3'h7},
             '{ALX_OP_ANDI, 1'h0, 7'h05, 8'hF0, 8'h01, 8'h0F, 8'h00, 3'h4},
             '{ALX_OP_ANDF, 1'h0, 7'h7F, 8'h3C, 8'h0F, 8'h00, 8'h0C, 3'h0},
             '{ALX_OP_ANDF, 1'h1, 7'h05, 8'hAA, 8'h55, 8'h00, 8'h00, 3'h4},
             '{ALX_OP_ADDF, 1'h0, 7'h05, 8'h80, 8'h80, 8'h00, 8'h00, 3'h5},
             '{ALX_OP_ADDF, 1'h1, 7'h05, 8'h12, 8'h34, 8'h00, 8'h46, 3'h0},
             '{ALX_OP_ARITH_SHIFT_RIGHT, 1'h0, 7'h05, 8'h00, 8'h81, 8'h00, 8'hC0, 3'h1},
             '{ALX_OP_ARITH_SHIFT_RIGHT, 1'h1, 7'h05, 8'h00, 8'h02, 8'h00, 8'h01, 3'h0},
             '{ALX_OP_ADDC, 1'h0, 7'h05, 8'h08, 8'h08, 8'h00, 8'h10, 3'h2},
             '{ALX_OP_BCLR, 1'h1, 7'h05, 8'h00, 8'hFF, 8'h07, 8'h7F, 3'h0},
             '{ALX_OP_BCLR, 1'h1, 7'h05, 8'h00, 8'h01, 8'h00, 8'h00, 3'h0}};
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    bus(0, REG_STATUS, 32'h0);
    chk(got, 32'h0);
    bus(0, REG_PTR1, 32'h0);
    chk(got, 32'h0);
    // table of operations: flags then result from the chosen destination
    foreach (rows[k])
    begin
      q = rows[k];
      load_file(q.fa, q.fil);
      bus(1, REG_ACC, {24'h0, q.acc});
      exec(q.op, q.d, q.fa, q.imm, q.imm[2:0], 1'h0);
      bus(0, REG_STATUS, 32'h0);
      chk(got, {29'h0, q.flg});
      if (q.d) get_file(q.fa);
      else bus(0, REG_ACC, 32'h0);
      chk(got, {24'h0, q.res});
    end
    // carry flag feeds the add with carry
    load_file(7'h05, 8'h0F);
    bus(1, REG_ACC, 32'hFF);
    exec(ALX_OP_ADDI, 1'h0, 7'h00, 8'h01, 3'h0, 1'h0);
    bus(1, REG_ACC, 32'h0);
    exec(ALX_OP_ADDC, 1'h0, 7'h05, 8'h00, 3'h0, 1'h0);
    bus(0, REG_ACC, 32'h0);
    chk(got, 32'h10);
    // pointer adds wrap both ways and leave flags alone
    bus(1, REG_PTR0, 32'hFFFF);
    exec(ALX_OP_PADD, 1'h0, 7'h00, 8'h01, 3'h0, 1'h0);
    bus(1, REG_PTR1, 32'h0);
    exec(ALX_OP_PADD, 1'h0, 7'h00, 8'hE0, 3'h0, 1'h1);
    exec(ALX_OP_PADD, 1'h0, 7'h00, 8'h1F, 3'h0, 1'h0);
    bus(0, REG_PTR0, 32'h0);
    chk(got, 32'h1F);
    bus(0, REG_PTR1, 32'h0);
    chk(got, 32'hFFE0);
    bus(0, REG_STATUS, 32'h0);
    chk(got, 32'h2);
    // indirect port with pointer msb set stalls once, clear msb does not
    bus(1, REG_PTR0, 32'h8005);
    bus(1, REG_ACC, 32'hFF);
    exec(ALX_OP_ANDF, 1'h0, 7'h00, 8'h00, 3'h0, 1'h0);
    bus(0, REG_ACC, 32'h0);
    chk(got, 32'h0F);
    chk(busy_cnt, 1);
    bus(1, REG_PTR0, 32'h0005);
    exec(ALX_OP_ANDF, 1'h0, 7'h00, 8'h00, 3'h0, 1'h0);
    chk(busy_cnt, 1);
    // unmapped place refused, read-only status ignores writes
    bus(1, 8'h18, 32'h1);
    chk(r, RESP_SLVERR);
    bus(0, 8'h18, 32'h0);
    chk(r, RESP_SLVERR);
    bus(1, REG_STATUS, 32'hFF);
    chk(r, RESP_OKAY);
    bus(0, REG_STATUS, 32'h0);
    chk(got, 32'h2);
    bus(1, REG_RESULT, 32'h1);
    chk(r, RESP_OKAY);
    bus(0, REG_RESULT, 32'h0);
    chk(got, 32'h0F);
    bus(0, REG_CTRL, 32'h0);
    chk(got, 32'h4);
    // reset in mid-run: accumulator, pointer and flags back to zero
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    bus(0, REG_ACC, 32'h0);
    chk(got, 32'h0);
    bus(0, REG_PTR0, 32'h0);
    chk(got, 32'h0);
    bus(0, REG_STATUS, 32'h0);
    chk(got, 32'h0);
    close_out();
  end
endmodule

bind alx_core alx_core_chk chk_u (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
  .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
  .s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o),
  .s_axi_bresp_o(s_axi_bresp_o), .s_axi_bvalid_o(s_axi_bvalid_o),
  .s_axi_bready_i(s_axi_bready_i), .s_axi_arvalid_i(s_axi_arvalid_i),
  .s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o),
  .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i), .busy_o(busy_o));
